// ---- design/latched_config_shadow.sv ----
`include "shadow_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module latched_config_shadow #(
	parameter int unsigned CHANNELS  = 4,
	parameter int unsigned VALID_CYC = `VALID_DELAY_CYC
) (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               sys_rst,
	// avalon-mm slave, word addressed
	input  wire shadow_pkg::av_req_t av_req,
	output var  logic [31:0]        readdata,
	output var  logic               waitrequest,
	output var  logic               readdatavalid,
	// slow-rate pins from the outside
	input  wire logic               first_pin_in,
	input  wire logic               second_pin_in,
	// conversion cycle end from the sequencer
	input  wire logic               cycle_done,
	// decoded active configuration, programmed pointer override and latched valid to the converter
	output var  shadow_pkg::conv_cfg_t conv_cfg,
	output var  logic               force_slow,
	output var  logic               ptr_skip_en,
	output var  logic               latched_valid
);
	import shadow_pkg::*;

	// channel-off reset from channel count
	localparam logic [3:0] OFF_DEFAULT =
		(CHANNELS >= 4) ? 4'h0 : (CHANNELS == 3) ? 4'h1 : (CHANNELS == 2) ? 4'h3 : 4'h7; // [RULE13]
	localparam logic [15:0] CTL_DEFAULT = `CTL_RESET | {8'h00, OFF_DEFAULT, 4'h0};
	localparam logic [19:0] VALID_CNT = 20'(VALID_CYC);

	logic [15:0]          prog_ctrl_r;
	logic [15:0]          prog_range_r;
	logic [15:0]          act_ctrl_r;
	logic [15:0]          act_range_r;
	logic [15:0]          lat_ctrl_r;
	logic [15:0]          lat_range_r;
	logic                 lat_seen_r;
	logic                 res_valid_r;
	logic                 ptr_override_r;
	logic [19:0]          settle_cnt_r;
	refresh_state_t       rf_state_r;
	refresh_state_t       rf_state_nxt;
	logic [1:0]           pin1_sync_r;
	logic [1:0]           pin2_sync_r;
	logic                 cyc_sync_r;
	logic                 cyc_dly_r;
	logic                 ack_r;

	// bus decode
	wire                  req_any    = (av_req.read | av_req.write) & ~ack_r;
	// writes commit at the edge that sees waitrequest low, as the master does
	wire                  wr_go      = av_req.write & ~waitrequest;
	wire                  rd_go      = av_req.read & ~ack_r;
	wire                  hit_pctl   = av_req.address == `IDX_PROG_CTRL;
	wire                  hit_prng   = av_req.address == `IDX_PROG_RANGE;
	wire                  hit_cmd    = av_req.address == `IDX_CMD;
	wire                  hit_lrng   = av_req.address == `IDX_LAT_RANGE;
	wire                  refresh_wr = wr_go & hit_cmd & av_req.writedata[`CMD_REFRESH_BIT];

	// a rate change outside sleep waits for the running conversion cycle to end
	wire                  rate_change = prog_ctrl_r[`CTL_MODE_HI:`CTL_MODE_LO] !=
	                                    act_ctrl_r[`CTL_MODE_HI:`CTL_MODE_LO];
	wire                  cycle_end   = cyc_sync_r & ~cyc_dly_r;
	wire                  in_sleep    = act_ctrl_r[`CTL_MODE_HI:`CTL_MODE_LO] == MODE_SLEEP;
	wire                  promote;

	// refresh sequencing
	always_comb begin
		rf_state_nxt = rf_state_r;
		case (rf_state_r)
			RF_IDLE: begin
				if (refresh_wr)
					rf_state_nxt = (rate_change && !in_sleep) ? RF_WAIT : RF_SETTLE; // [RULE18]
			end
			RF_WAIT: begin
				if (cycle_end)
					rf_state_nxt = RF_SETTLE; // [RULE18]
			end
			RF_SETTLE: begin
				if (refresh_wr)
					rf_state_nxt = (rate_change && !in_sleep) ? RF_WAIT : RF_SETTLE;
				else if (settle_cnt_r == VALID_CNT - 20'd1)
					rf_state_nxt = RF_IDLE;
			end
			default: rf_state_nxt = RF_IDLE;
		endcase
	end

	assign promote = (rf_state_r != RF_WAIT && rf_state_nxt == RF_SETTLE && refresh_wr)
	              || (rf_state_r == RF_WAIT && cycle_end);

	// pins come from outside the clock domain
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin1_sync_r <= 2'b00;
			pin2_sync_r <= 2'b00;
			cyc_sync_r  <= 1'b0;
			cyc_dly_r   <= 1'b0;
		end else begin
			pin1_sync_r <= {pin1_sync_r[0], first_pin_in};
			pin2_sync_r <= {pin2_sync_r[0], second_pin_in};
			cyc_sync_r  <= cycle_done;
			cyc_dly_r   <= cyc_sync_r;
		end
	end

	// programmed registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prog_ctrl_r    <= CTL_DEFAULT;
			prog_range_r   <= `RANGE_RESET;
			ptr_override_r <= 1'b0;
		end else if (wr_go) begin
			if (hit_pctl) begin
				prog_ctrl_r    <= av_req.writedata[15:0] & `CTL_IMPL_MASK;
				ptr_override_r <= av_req.writedata[1];
			end
			if (hit_prng)
				prog_range_r <= av_req.writedata[15:0];
		end
	end

	// active and latched images move together on one edge
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			act_ctrl_r  <= CTL_DEFAULT;
			act_range_r <= `RANGE_RESET;
			lat_ctrl_r  <= CTL_DEFAULT;
			lat_range_r <= `RANGE_RESET;
			lat_seen_r  <= 1'b0;
		end else begin
			if (promote) begin
				lat_ctrl_r  <= act_ctrl_r & `CTL_IMPL_MASK; // [RULE1] [RULE14] [RULE19]
				lat_range_r <= act_range_r;                 // [RULE15] [RULE19]
				act_ctrl_r  <= prog_ctrl_r;
				act_range_r <= prog_range_r;                // [RULE16] [RULE17]
				lat_seen_r  <= 1'b1;                        // [RULE3]
			end else if (wr_go && hit_lrng) begin
				lat_range_r <= av_req.writedata[15:0];
			end
		end
	end

	// results and latched images valid after settle delay
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rf_state_r   <= RF_IDLE;
			settle_cnt_r <= 20'd0;
			res_valid_r  <= 1'b0;
		end else begin
			rf_state_r <= rf_state_nxt;
			if (promote) begin
				settle_cnt_r <= 20'd0;
				res_valid_r  <= 1'b0;
			end else if (rf_state_r == RF_SETTLE) begin
				settle_cnt_r <= settle_cnt_r + 20'd1;
				if (rf_state_nxt == RF_IDLE)
					res_valid_r <= 1'b1; // [RULE2]
			end else if (refresh_wr) begin
				res_valid_r <= 1'b0;
			end
		end
	end

	// converter decode of the active image
	wire [3:0]            act_mode = act_ctrl_r[`CTL_MODE_HI:`CTL_MODE_LO];
	wire [1:0]            act_pin1 = act_ctrl_r[`CTL_PIN1_HI:`CTL_PIN1_LO];
	wire [1:0]            act_pin2 = act_ctrl_r[`CTL_PIN2_HI:`CTL_PIN2_LO];
	wire                  slow_req = (act_pin1 == PIN_SLOW_IN && pin1_sync_r[1])  // [RULE9]
	                              || (act_pin2 == PIN_SLOW_IN && pin2_sync_r[1]); // [RULE8] [RULE10]
	wire                  is_sleep = act_mode == MODE_SLEEP;
	wire                  is_rsvd  = act_mode[3:2] == 2'b11 && !is_sleep;
	wire [3:0]            chan_on;
	conv_cfg_t            cfg_nxt;

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_chan
			// field bit 7 is channel 1
			assign chan_on[ch] = !act_ctrl_r[`CTL_OFF_HI - ch] && !is_sleep; // [RULE11] [RULE7]
		end
	endgenerate

	always_comb begin
		cfg_nxt           = '0;
		cfg_nxt.adaptive  = act_mode[3:2] == 2'b00;                   // [RULE4]
		cfg_nxt.rate_code = act_mode[3] ? act_mode : {2'b00, act_mode[1:0]}; // [RULE5]
		if (slow_req && !act_mode[3])
			cfg_nxt.rate_code = {2'b00, 2'b11};                       // [RULE10]
		case (act_mode)
			MODE_SINGLE:    cfg_nxt.single = 1'b1;                    // [RULE6]
			MODE_SINGLE_X8: begin
				cfg_nxt.single = 1'b1;
				cfg_nxt.avg_x8 = 1'b1;
			end
			MODE_FAST:      cfg_nxt.fast   = 1'b1;
			MODE_BURST:     cfg_nxt.burst  = 1'b1;
			MODE_SLEEP:     cfg_nxt.sleep  = 1'b1;                    // [RULE7]
			default:        cfg_nxt.reserved = is_rsvd;
		endcase
		cfg_nxt.chan_on = chan_on;
	end

	// read mux
	logic [31:0]          rd_mux;
	always_comb begin
		case (av_req.address)
			`IDX_PROG_CTRL:  rd_mux = {16'h0000, prog_ctrl_r | {14'h0, ptr_override_r, 1'b0}};
			`IDX_PROG_RANGE: rd_mux = {16'h0000, prog_range_r};
			`IDX_ACT_CTRL:   rd_mux = {16'h0000, act_ctrl_r};
			`IDX_ACT_RANGE:  rd_mux = {16'h0000, act_range_r};
			`IDX_LAT_CTRL:   rd_mux = {16'h0000, lat_ctrl_r & `CTL_IMPL_MASK}; // [RULE14]
			`IDX_LAT_RANGE:  rd_mux = {16'h0000, lat_range_r};
			`IDX_STATUS:     rd_mux = {28'h000_0000, is_sleep, rf_state_r != RF_IDLE,
			                           res_valid_r, lat_seen_r & res_valid_r};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	// registered outputs; one wait cycle then ack
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_r         <= 1'b0;
			readdata      <= 32'h0000_0000;
			readdatavalid <= 1'b0;
			conv_cfg      <= '0;
			force_slow    <= 1'b0;
			ptr_skip_en   <= 1'b1;
			latched_valid <= 1'b0;
		end else begin
			ack_r         <= req_any;
			readdatavalid <= rd_go;
			if (rd_go)
				readdata <= rd_mux;
			conv_cfg      <= cfg_nxt;
			force_slow    <= slow_req;
			ptr_skip_en   <= !ptr_override_r;                    // [RULE12]
			latched_valid <= lat_seen_r & res_valid_r;           // [RULE2] [RULE3]
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~req_any;
	end

endmodule : latched_config_shadow

`default_nettype wire

// ---- design/shadow_consts.svh ----
// Functional notes
// RULE1: every refresh variant latches prior control settings
// RULE2: latched images valid 1 ms after refresh
// RULE3: latched control invalid until first refresh
// RULE4: modes 0-3 adaptive 1024/256/64/8 SPS
// RULE5: modes 4-7 fixed 1024/256/64/8 SPS
// RULE6: 8 single,9 single 8x,A fast,B burst,F sleep
// RULE7: one mode at a time; sleep converts nothing
// RULE8: second pin function decode, default GPIO input
// RULE9: first pin function decode, default slow input
// RULE10: slow pin high forces 8 SPS; code forces the 8 SPS rate code in modes 0-7 only
// RULE11: channel-off bits exclude channels from conversion
// RULE12: pointer skips inactive channels unless override set
// RULE13: channel-off default depends on channel count
// RULE14: latched control low nibble reads zero
// RULE15: every refresh latches prior range settings
// RULE16: sense range codes 100 uni, 100 bi, 50 bi
// RULE17: bus range codes 32 uni, 32 bi, 16 bi
// RULE18: rate change applies after current cycle completes
// RULE19: latch in same cycle as promotion to active
`ifndef SHADOW_CONSTS_SVH
`define SHADOW_CONSTS_SVH

// register indices; byte address is index times four
`define IDX_PROG_CTRL    8'h01
`define IDX_PROG_RANGE   8'h1D
`define IDX_ACT_CTRL     8'h21
`define IDX_ACT_RANGE    8'h22
`define IDX_LAT_CTRL     8'h23
`define IDX_LAT_RANGE    8'h24
`define IDX_CMD          8'h30
`define IDX_STATUS       8'h31

// command register bits
`define CMD_REFRESH_BIT  0
`define CMD_CYCLE_BIT    1

// status register bits
`define ST_LAT_VALID     0
`define ST_RES_VALID     1
`define ST_PENDING       2
`define ST_SLEEP         3

// control field positions
`define CTL_MODE_HI      15
`define CTL_MODE_LO      12
`define CTL_PIN2_HI      11
`define CTL_PIN2_LO      10
`define CTL_PIN1_HI      9
`define CTL_PIN1_LO      8
`define CTL_OFF_HI       7
`define CTL_OFF_LO       4

`define CTL_RESET        16'h0700
`define RANGE_RESET      16'h0000
`define CTL_IMPL_MASK    16'hFFF0

// timing
`define CLK_HZ           25000000
`define VALID_DELAY_US   1000
`define VALID_DELAY_CYC  ((`CLK_HZ / 1000000) * `VALID_DELAY_US)

`endif

// ---- design/shadow_pkg.sv ----
package shadow_pkg;

	typedef enum logic [3:0] {
		MODE_ADAPT_1024 = 4'b0000,
		MODE_ADAPT_256  = 4'b0001,
		MODE_ADAPT_64   = 4'b0010,
		MODE_ADAPT_8    = 4'b0011,
		MODE_FIX_1024   = 4'b0100,
		MODE_FIX_256    = 4'b0101,
		MODE_FIX_64     = 4'b0110,
		MODE_FIX_8      = 4'b0111,
		MODE_SINGLE     = 4'b1000,
		MODE_SINGLE_X8  = 4'b1001,
		MODE_FAST       = 4'b1010,
		MODE_BURST      = 4'b1011,
		MODE_SLEEP      = 4'b1111
	} sample_mode_t;

	typedef enum logic [1:0] {
		PIN_ALARM    = 2'b00,
		PIN_GP_IN    = 2'b01,
		PIN_GP_OUT   = 2'b10,
		PIN_SLOW_IN  = 2'b11
	} pin_func_t;

	typedef enum logic [1:0] {
		SENSE_UNI_100 = 2'b00,
		SENSE_BI_100  = 2'b01,
		SENSE_BI_50   = 2'b10,
		SENSE_RSVD    = 2'b11
	} sense_range_t;

	typedef enum logic [1:0] {
		RAIL_UNI_32 = 2'b00,
		RAIL_BI_32  = 2'b01,
		RAIL_BI_16  = 2'b10,
		RAIL_RSVD   = 2'b11
	} rail_range_t;

	typedef enum logic [1:0] {
		RF_IDLE    = 2'b00,
		RF_WAIT    = 2'b01,
		RF_SETTLE  = 2'b10
	} refresh_state_t;

	// decoded effect of the active control image on the converter
	typedef struct packed {
		logic [3:0] rate_code;
		logic       adaptive;
		logic       single;
		logic       avg_x8;
		logic       fast;
		logic       burst;
		logic       sleep;
		logic       reserved;
		logic [3:0] chan_on;
	} conv_cfg_t;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} av_req_t;

endpackage : shadow_pkg

// ---- sim/shadow_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module shadow_sva #(
	parameter int unsigned VALID_CYC = 20
) (
	// clock and reset
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	// register bus
	input wire shadow_pkg::av_req_t   av_req,
	input wire logic [31:0]           readdata,
	input wire logic                  waitrequest,
	input wire logic                  readdatavalid,
	// converter side
	input wire shadow_pkg::conv_cfg_t conv_cfg,
	input wire logic                  latched_valid
);
	import shadow_pkg::*;
	wire logic        refresh_ack;
	logic      [31:0] since_r;
	assign refresh_ack = av_req.write && !waitrequest && av_req.address == 8'h30
		&& av_req.writedata[0];
	// saturates so a long idle stretch never wraps to zero
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			since_r <= 32'h0000_0000;
		else if (refresh_ack)
			since_r <= 32'h0000_0001;
		else if (since_r != 32'h0000_0000 && since_r < VALID_CYC)
			since_r <= since_r + 32'h0000_0001;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence any_req;
		(av_req.read || av_req.write) && waitrequest;
	endsequence
	sequence rd_req;
		av_req.read && waitrequest;
	endsequence
	chk_req_ack: assert property (any_req |=> !waitrequest)
		else $error("request not acknowledged next cycle");
	chk_ack_single: assert property (!waitrequest |=> waitrequest)
		else $error("acknowledge longer than one cycle");
	chk_rd_valid: assert property (rd_req |=> readdatavalid && !waitrequest)
		else $error("read data valid missing at acknowledge");
	chk_wr_no_rdv: assert property (av_req.write && waitrequest |=> !readdatavalid)
		else $error("read data valid on a write");
	chk_rdata_hold: assert property ($changed(readdata) |-> $past(av_req.read && waitrequest))
		else $error("read data moved without a read");
	chk_mode_excl: assert property ($onehot0({conv_cfg.adaptive, conv_cfg.single,
		conv_cfg.fast, conv_cfg.burst, conv_cfg.sleep, conv_cfg.reserved}))
		else $error("more than one sampling mode decoded");
	chk_x8_single: assert property (conv_cfg.avg_x8 |-> conv_cfg.single)
		else $error("averaging decoded outside single-shot");
	chk_valid_delay: assert property ($rose(latched_valid) |-> since_r >= VALID_CYC)
		else $error("latched images valid too early");
	chk_valid_first: assert property (latched_valid |-> since_r != 32'h0000_0000)
		else $error("latched images valid before any refresh");
endmodule : shadow_sva
bind latched_config_shadow shadow_sva #(.VALID_CYC(VALID_CYC)) u_shadow_sva (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .av_req(av_req), .readdata(readdata),
	.waitrequest(waitrequest), .readdatavalid(readdatavalid), .conv_cfg(conv_cfg),
	.latched_valid(latched_valid));
`default_nettype wire

// ---- sim/tb_latched_config_shadow.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_latched_config_shadow;
	import shadow_pkg::*;
	localparam int unsigned VCYC = 20;
	logic        ref_clk       = 1'b0;
	logic        sys_rst       = 1'b1;
	av_req_t     av_req        = '0;
	logic        first_pin_in  = 1'b0;
	logic        second_pin_in = 1'b0;
	logic        cycle_done    = 1'b0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        readdatavalid;
	logic        force_slow;
	logic        ptr_skip_en;
	logic        latched_valid;
	conv_cfg_t   conv_cfg;
	logic [31:0] q;
	int          error_cnt = 0;
	int          checked   = 0;
	int          cyc       = 0;
	int          act_c     = 'h0700;
	int          act_r     = 0;
	int          pc, pr, m;
	latched_config_shadow #(.VALID_CYC(VCYC)) u_latched_config_shadow (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .av_req(av_req), .readdata(readdata),
		.waitrequest(waitrequest), .readdatavalid(readdatavalid),
		.first_pin_in(first_pin_in), .second_pin_in(second_pin_in),
		.cycle_done(cycle_done), .conv_cfg(conv_cfg), .force_slow(force_slow),
		.ptr_skip_en(ptr_skip_en), .latched_valid(latched_valid));
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 5000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	// request held until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		av_req <= '{address: a, read: !w, write: w, writedata: d};
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		q = readdata;
		av_req <= '0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask : rd
	initial begin
		void'($urandom(40));
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(8'h23, 32'h0000_0700, "lat_ctrl_reset");
		rd(8'h24, 32'h0000_0000, "lat_range_reset");
		rd(8'h7F, 32'h0000_0000, "unmapped");
		chk("valid_before", 32'h0000_0000, {31'h0, latched_valid});
		// every mode code once, reserved ones included
		for (m = 0; m < 16; m++) begin
			pc = {m[3:0], 12'($urandom)};
			pr = 16'($urandom);
			first_pin_in <= 1'($urandom);
			second_pin_in <= 1'($urandom);
			bus(1'b1, 8'h23, $urandom);
			bus(1'b1, 8'h01, pc);
			bus(1'b1, 8'h1D, pr);
			bus(1'b1, 8'h30, 32'h0000_0001);
			repeat (3) @(posedge ref_clk);
			cycle_done <= 1'b1;
			@(posedge ref_clk);
			cycle_done <= 1'b0;
			repeat (VCYC + 10) @(posedge ref_clk);
			chk("valid", 32'h0000_0001, {31'h0, latched_valid});
			rd(8'h23, act_c & 'hFFF0, "lat_ctrl");
			rd(8'h24, act_r, "lat_range");
			act_c = pc;
			act_r = pr;
			rd(8'h22, pr, "act_range");
			rd(8'h21, pc & 'hFFF0, "act_ctrl");
			rd(8'h01, pc & 'hFFF2, "prog_ctrl");
			rd(8'h31, {28'h0, m == 15, 1'b0, 2'b11}, "status");
			// chan_on bit 0 is channel 1; sleep turns every channel off
			chk("cfg", {m < 4, m == 8 || m == 9, m == 9, m == 10, m == 11, m == 15,
				m > 11 && m < 15, (m == 15) ? 4'h0 : {~pc[4], ~pc[5], ~pc[6], ~pc[7]}},
				conv_cfg[10:0]);
			chk("rate", (m > 7) ? m : (((pc[9:8] == 3 && first_pin_in)
				|| (pc[11:10] == 3 && second_pin_in)) ? 3 : m % 4),
				conv_cfg.rate_code);
			chk("slow", (pc[9:8] == 3 && first_pin_in) || (pc[11:10] == 3 && second_pin_in),
				force_slow);
			chk("skip", !pc[1], ptr_skip_en);
		end
		conclude();
	end
endmodule : tb_latched_config_shadow
`default_nettype wire
